// [verilog/mpm_defs.svh]
`ifndef MPM_DEFS_SVH
`define MPM_DEFS_SVH
`define MPM_FIX_BASE  16'h0211
`define MPM_USR_FIRST 16'h0001
`define MPM_USR_LAST  16'h0100
`define MPM_PNO_MAX   16'h0FFF
`define MPM_TAB_N     32
`define MPM_IDX_W     5
`define MPM_UREG_END  10'h101
`define MPM_EXC_NONE  8'h00
`define MPM_EXC_ADDR  8'h02
`define MPM_BE_B      4'h1
`define MPM_BE_W      4'h3
`define MPM_BE_HI     4'hC
`define MPM_BE_ALL    4'hF
`endif

// [verilog/mpm_pkg.sv]
package mpm_pkg;
	typedef enum logic [2:0] {
		MPM_BYTE  = 3'h0,
		MPM_WORD  = 3'h1,
		MPM_RAW4  = 3'h2,
		MPM_DWORD = 3'h3,
		MPM_STR   = 3'h6
	} mpm_cls_t;
	typedef enum logic [1:0] {
		MPM_A_USR = 2'h0,
		MPM_A_RSV = 2'h1,
		MPM_A_BAD = 2'h2,
		MPM_A_FIX = 2'h3
	} mpm_area_t;
endpackage : mpm_pkg

// [verilog/mpm_fixed_dec.sv]
`timescale 1ns/100ps
`include "mpm_defs.svh"
module mpm_fixed_dec import mpm_pkg::*; (
	input  wire logic [15:0] addr, // Register address of the request.
	output mpm_area_t        area, // Address area.
	output logic      [15:0] num,  // Fixed-map parameter number.
	output logic             half, // Second register of the pair.
	output logic             over  // Parameter number out of range.
);
	logic [15:0] off;

	always_comb begin
		off = addr - `MPM_FIX_BASE;
		num = {1'b0, off[15:1]} + 16'h0001;
		half = off[0];
		over = 1'b0;
		if (addr == 16'h0000) begin
			area = MPM_A_BAD;
		end else if (addr <= `MPM_USR_LAST) begin
			area = MPM_A_USR;
		end else if (addr < `MPM_FIX_BASE) begin
			area = MPM_A_RSV;
		end else begin
			area = MPM_A_FIX;
			over = (num > `MPM_PNO_MAX);
		end
	end
endmodule : mpm_fixed_dec

// [verilog/mpm_user_map.sv]
`timescale 1ns/100ps
`include "mpm_defs.svh"
module mpm_user_map import mpm_pkg::*; (
	input  wire logic                     core_clk,   // Clock.
	input  wire logic                     sys_rst,    // Synchronous reset.
	input  wire logic [`MPM_TAB_N*16-1:0] map_tab,    // Mapping table, entry 0 lowest.
	output logic      [15:0]              scan_num,   // Entry under check.
	input  wire logic                     scan_valid, // Entry names a parameter.
	input  wire mpm_cls_t                 scan_cls,   // Class of that parameter.
	input  wire logic [7:0]               scan_slen,  // String length in characters.
	input  wire logic                     scan_pwd,   // Password parameter.
	input  wire logic                     scan_arr,   // Whole-array parameter.
	output logic                          map_valid,  // All entries before the first zero entry valid.
	input  wire logic [8:0]               look_reg,   // User register to resolve.
	output logic                          hit,        // Register is mapped.
	output logic      [15:0]              hit_num,    // Parameter or fragment number.
	output logic                          hit_half,   // Second register of a pair.
	output logic                          hit_str,    // Register belongs to a string.
	output logic                          hit_off0,   // First register of its parameter.
	output logic      [`MPM_IDX_W-1:0]    hit_idx     // Table entry hit.
);
	logic [`MPM_IDX_W-1:0] idx_q, idx_d;
	logic [8:0]            nreg_q, nreg_d;
	logic                  bad_q, bad_d, end_q, end_d, ok_q, ok_d;
	logic [8:0]            cur_len;
	logic                  cur_str;
	logic [8:0]            start_q [`MPM_TAB_N];
	logic [8:0]            len_q   [`MPM_TAB_N];
	logic                  str_q   [`MPM_TAB_N];
	logic [`MPM_TAB_N-1:0] hit_v;
	logic [8:0]            off;
	logic [15:0]           ent;

	assign scan_num = map_tab[{idx_q, 4'h0} +: 16];
	assign map_valid = ok_q;

	always_comb begin
		cur_len = 9'h000;
		cur_str = 1'b0;
		end_d = end_q;
		bad_d = bad_q;
		if (end_q || scan_num == 16'h0000) begin
			end_d = 1'b1;
		end else if (!scan_valid || scan_pwd || scan_arr) begin
			bad_d = 1'b1;
		end else begin
			unique case (scan_cls)
				MPM_BYTE, MPM_WORD: cur_len = 9'h001;
				MPM_DWORD, MPM_RAW4: cur_len = 9'h002;
				MPM_STR: begin
					cur_str = 1'b1;
					cur_len = ({1'b0, scan_slen} + 9'h002) >> 1;
				end
				default: bad_d = 1'b1;
			endcase
		end
		if ({1'b0, nreg_q} + {1'b0, cur_len} > `MPM_UREG_END) begin
			cur_len = 9'h000;
		end
		nreg_d = nreg_q + cur_len;
		idx_d = idx_q + 5'h01;
		ok_d = ok_q;
		if (&idx_q) begin
			ok_d = !bad_d;
			nreg_d = 9'(`MPM_USR_FIRST);
			bad_d = 1'b0;
			end_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			idx_q <= 5'h00;
			nreg_q <= 9'(`MPM_USR_FIRST);
			bad_q <= 1'b0;
			end_q <= 1'b0;
			ok_q <= 1'b0;
		end else begin
			idx_q <= idx_d;
			nreg_q <= nreg_d;
			bad_q <= bad_d;
			end_q <= end_d;
			ok_q <= ok_d;
		end
	end

	for (genvar i = 0; i < `MPM_TAB_N; i++) begin : g_ent
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				start_q[i] <= 9'h000;
				len_q[i] <= 9'h000;
				str_q[i] <= 1'b0;
			end else if (idx_q == i[`MPM_IDX_W-1:0]) begin
				start_q[i] <= nreg_q;
				len_q[i] <= cur_len;
				str_q[i] <= cur_str;
			end
		end
		assign hit_v[i] = (len_q[i] != 9'h000) && (look_reg >= start_q[i])
			&& ({1'b0, look_reg} < {1'b0, start_q[i]} + {1'b0, len_q[i]});
	end

	always_comb begin
		hit = 1'b0;
		hit_idx = 5'h00;
		for (int k = `MPM_TAB_N - 1; k >= 0; k--) begin
			if (hit_v[k]) begin
				hit = 1'b1;
				hit_idx = k[`MPM_IDX_W-1:0];
			end
		end
		off = look_reg - start_q[hit_idx];
		ent = map_tab[{hit_idx, 4'h0} +: 16];
		hit_str = str_q[hit_idx];
		hit_num = hit_str ? ent + 16'h0001 + {8'h00, off[8:1]} : ent;
		hit_half = off[0];
		hit_off0 = (off == 9'h000);
	end
endmodule : mpm_user_map

// [verilog/mpm_bridge.sv]
`timescale 1ns/100ps
`include "mpm_defs.svh"
module mpm_bridge import mpm_pkg::*; (
	input  wire logic                     core_clk,      // Clock, 125 MHz.
	input  wire logic                     sys_rst,       // Synchronous reset.
	input  wire logic                     req_valid,     // Register access offered.
	output logic                          req_ready,     // Access can be taken.
	input  wire logic                     req_write,     // Write access.
	input  wire logic                     req_first,     // First register of a request.
	input  wire logic                     req_last,      // Last register of a request.
	input  wire logic [15:0]              req_addr,      // Register address.
	input  wire logic [15:0]              req_wdata,     // Write data.
	output logic                          rsp_valid,     // Answer strobe.
	output logic      [15:0]              rsp_rdata,     // Read data.
	output logic      [7:0]               rsp_exc,       // Exception code, zero if none.
	input  wire logic                     hi_word_first, // Word-order setting.
	output logic      [15:0]              ps_num,        // Parameter looked up.
	input  wire logic                     ps_valid,      // Parameter exists.
	input  wire mpm_cls_t                 ps_cls,        // Parameter class.
	input  wire logic                     ps_wrable,     // Parameter writable.
	input  wire logic [31:0]              ps_rdata,      // Parameter value, byte 0 lowest.
	output logic                          ps_wr_en,      // Parameter write strobe.
	output logic      [15:0]              ps_wr_num,     // Parameter written.
	output logic      [31:0]              ps_wr_data,    // Write value.
	output logic      [3:0]               ps_wr_be,      // Byte enables.
	output logic                          ps_wr_nul,     // Terminate string after bytes.
	input  wire logic [`MPM_TAB_N*16-1:0] map_tab,       // Mapping table.
	output logic      [15:0]              scan_num,      // Table entry under check.
	input  wire logic                     scan_valid,    // Entry names a parameter.
	input  wire mpm_cls_t                 scan_cls,      // Entry class.
	input  wire logic [7:0]               scan_slen,     // Entry string length.
	input  wire logic                     scan_pwd,      // Entry is a password.
	input  wire logic                     scan_arr,      // Entry is a whole array.
	output logic                          map_valid      // Mapping table valid.
);
	mpm_area_t             area;
	logic [15:0]           fnum;
	logic                  fhalf;
	logic                  fover;
	logic                  uhit;
	logic [15:0]           unum;
	logic                  uhalf;
	logic                  ustr;
	logic                  uoff0;
	logic [`MPM_IDX_W-1:0] uidx;
	logic [15:0]           rnum;
	logic                  rhalf;
	logic                  mapped;
	logic                  take;
	logic                  wok;
	logic                  sgate;
	logic [7:0]            exc;
	logic [15:0]           rd;
	logic [15:0]           ps_hi;
	logic [15:0]           ps_lo;

	logic                  rsp_valid_q, rsp_valid_d;
	logic [15:0]           rsp_rdata_q, rsp_rdata_d;
	logic [7:0]            rsp_exc_q, rsp_exc_d;
	logic                  wen_q, wen_d;
	logic [15:0]           wnum_q, wnum_d;
	logic [31:0]           wdata_q, wdata_d;
	logic [3:0]            wbe_q, wbe_d;
	logic                  wnul_q, wnul_d;
	logic                  pend_q, pend_d;
	logic [15:0]           pnum_q, pnum_d;
	logic [15:0]           pword_q, pword_d;
	logic                  sok_q, sok_d;
	logic [`MPM_IDX_W-1:0] sidx_q, sidx_d;

	mpm_fixed_dec u_fix (
		.addr (req_addr),
		.area (area),
		.num  (fnum),
		.half (fhalf),
		.over (fover)
	);

	mpm_user_map u_usr (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.map_tab    (map_tab),
		.scan_num   (scan_num),
		.scan_valid (scan_valid),
		.scan_cls   (scan_cls),
		.scan_slen  (scan_slen),
		.scan_pwd   (scan_pwd),
		.scan_arr   (scan_arr),
		.map_valid  (map_valid),
		.look_reg   (req_addr[8:0]),
		.hit        (uhit),
		.hit_num    (unum),
		.hit_half   (uhalf),
		.hit_str    (ustr),
		.hit_off0   (uoff0),
		.hit_idx    (uidx)
	);

	assign req_ready = !sys_rst;
	assign take = req_valid && req_ready;
	assign ps_hi = ps_rdata[31:16];
	assign ps_lo = ps_rdata[15:0];
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rsp_rdata_q;
	assign rsp_exc = rsp_exc_q;
	assign ps_wr_en = wen_q;
	assign ps_wr_num = wnum_q;
	assign ps_wr_data = wdata_q;
	assign ps_wr_be = wbe_q;
	assign ps_wr_nul = wnul_q;

	// ****************************************
	// Address resolution and read formatting.
	// ****************************************
	always_comb begin
		rnum = fnum;
		rhalf = fhalf;
		mapped = 1'b0;
		exc = `MPM_EXC_NONE;
		unique case (area)
			MPM_A_FIX: begin
				mapped = !fover && ps_valid;
				if (!mapped) begin
					exc = `MPM_EXC_ADDR;
				end
			end
			MPM_A_USR: begin
				rnum = unum;
				rhalf = uhalf;
				mapped = uhit && ps_valid;
			end
			MPM_A_RSV: mapped = 1'b0;
			MPM_A_BAD: exc = `MPM_EXC_ADDR;
		endcase
		ps_num = rnum;
		rd = 16'h0000;
		if (mapped) begin
			unique case (ps_cls)
				MPM_BYTE: rd = rhalf ? 16'h0000 : {8'h00, ps_rdata[7:0]};
				MPM_WORD: rd = rhalf ? 16'h0000 : ps_lo;
				MPM_DWORD: rd = (rhalf ^ hi_word_first) ? ps_hi : ps_lo;
				MPM_RAW4, MPM_STR: rd = rhalf ? ps_hi : ps_lo;
				default: rd = 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Response.
	// ****************************************
	always_comb begin
		rsp_valid_d = take;
		rsp_rdata_d = rsp_rdata_q;
		rsp_exc_d = rsp_exc_q;
		if (take) begin
			rsp_rdata_d = req_write ? 16'h0000 : rd;
			rsp_exc_d = exc;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 16'h0000;
			rsp_exc_q <= `MPM_EXC_NONE;
		end else begin
			rsp_valid_q <= rsp_valid_d;
			rsp_rdata_q <= rsp_rdata_d;
			rsp_exc_q <= rsp_exc_d;
		end
	end

	// ****************************************
	// Parameter writes.
	// ****************************************
	// A user string may only be written from its first register onward.
	assign sgate = !(area == MPM_A_USR && ustr) || uoff0
		|| (sok_q && sidx_q == uidx && !req_first);
	assign wok = take && req_write && mapped && ps_wrable && sgate;

	always_comb begin
		wen_d = 1'b0;
		wnum_d = wnum_q;
		wdata_d = wdata_q;
		wbe_d = wbe_q;
		wnul_d = 1'b0;
		pend_d = pend_q;
		pnum_d = pnum_q;
		pword_d = pword_q;
		sok_d = sok_q;
		sidx_d = sidx_q;
		if (take) begin
			pend_d = 1'b0;
			if (req_first) begin
				sok_d = 1'b0;
			end
			if (req_write && area == MPM_A_USR && ustr && uoff0) begin
				sok_d = 1'b1;
				sidx_d = uidx;
			end
		end
		if (wok) begin
			wnum_d = rnum;
			unique case (ps_cls)
				MPM_BYTE, MPM_WORD: begin
					wen_d = !rhalf;
					wdata_d = {16'h0000, req_wdata};
					wbe_d = (ps_cls == MPM_BYTE) ? `MPM_BE_B : `MPM_BE_W;
				end
				MPM_DWORD: begin
					if (!rhalf) begin
						pend_d = 1'b1;
						pnum_d = rnum;
						pword_d = req_wdata;
					end else if (pend_q && pnum_q == rnum && !req_first) begin
						wen_d = 1'b1;
						wbe_d = `MPM_BE_ALL;
						wdata_d = hi_word_first ? {pword_q, req_wdata} : {req_wdata, pword_q};
					end
				end
				MPM_RAW4, MPM_STR: begin
					wen_d = 1'b1;
					wdata_d = {req_wdata, req_wdata};
					wbe_d = rhalf ? `MPM_BE_HI : `MPM_BE_W;
					wnul_d = area == MPM_A_USR && ustr && req_last
						&& req_wdata[15:8] != 8'h00 && req_wdata[7:0] != 8'h00;
				end
				default: wen_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wen_q <= 1'b0;
			wnum_q <= 16'h0000;
			wdata_q <= 32'h0000_0000;
			wbe_q <= 4'h0;
			wnul_q <= 1'b0;
			pend_q <= 1'b0;
			pnum_q <= 16'h0000;
			pword_q <= 16'h0000;
			sok_q <= 1'b0;
			sidx_q <= 5'h00;
		end else begin
			wen_q <= wen_d;
			wnum_q <= wnum_d;
			wdata_q <= wdata_d;
			wbe_q <= wbe_d;
			wnul_q <= wnul_d;
			pend_q <= pend_d;
			pnum_q <= pnum_d;
			pword_q <= pword_d;
			sok_q <= sok_d;
			sidx_q <= sidx_d;
		end
	end

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	property p_pair;
		take && area == MPM_A_FIX && !fhalf ##1 take && req_addr == $past(req_addr) + 16'h0001
			|-> ps_num == $past(ps_num) && fhalf;
	endproperty
	a_pair: assert property (p_pair) else $error("register pair split");

	property p_byte_hi;
		take && !req_write && mapped && ps_cls == MPM_BYTE |=> rsp_rdata[15:8] == 8'h00;
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("byte read not zero extended");

	property p_unused_rd;
		take && !req_write && area == MPM_A_FIX && fhalf && (ps_cls == MPM_BYTE || ps_cls == MPM_WORD)
			|=> rsp_valid && rsp_rdata == 16'h0000;
	endproperty
	a_unused_rd: assert property (p_unused_rd) else $error("unused register read nonzero");

	property p_unused_wr;
		take && req_write && area == MPM_A_FIX && fhalf && (ps_cls == MPM_BYTE || ps_cls == MPM_WORD)
			|=> !ps_wr_en;
	endproperty
	a_unused_wr: assert property (p_unused_wr) else $error("unused register write acted");

	property p_lo_first;
		take && !req_write && mapped && ps_cls == MPM_DWORD && !rhalf && !hi_word_first
			|=> rsp_rdata == $past(ps_lo);
	endproperty
	a_lo_first: assert property (p_lo_first) else $error("low word not first");

	property p_hi_first;
		take && !req_write && mapped && ps_cls == MPM_DWORD && !rhalf && hi_word_first
			|=> rsp_rdata == $past(ps_hi);
	endproperty
	a_hi_first: assert property (p_hi_first) else $error("high word not first");

	property p_single_dw;
		take && req_write && req_first && req_last && ps_cls == MPM_DWORD |=> !ps_wr_en;
	endproperty
	a_single_dw: assert property (p_single_dw) else $error("half dword write acted");

	property p_dw_commit;
		ps_wr_en && ps_wr_be == `MPM_BE_ALL |-> $past(take) && !$past(req_first) && $past(rhalf);
	endproperty
	a_dw_commit: assert property (p_dw_commit) else $error("dword committed without pair");

	property p_exc;
		take && area == MPM_A_FIX && fover |=> rsp_valid && rsp_exc == `MPM_EXC_ADDR;
	endproperty
	a_exc: assert property (p_exc) else $error("missing address exception");

	property p_str_gate;
		take && req_write && area == MPM_A_USR && ustr && !uoff0 && req_first |=> !ps_wr_en;
	endproperty
	a_str_gate: assert property (p_str_gate) else $error("string written without first register");

	property p_served;
		take && !map_valid |=> rsp_valid;
	endproperty
	a_served: assert property (p_served) else $error("request dropped on invalid table");

	c_dw_commit: cover property (ps_wr_en && ps_wr_be == `MPM_BE_ALL);
	c_usr_str: cover property (take && area == MPM_A_USR && ustr && req_write ##1 take && !req_first);
	c_exc: cover property (rsp_valid && rsp_exc == `MPM_EXC_ADDR);
endmodule : mpm_bridge

// [test/mpm_store_model.sv]
`timescale 1ns/100ps
module mpm_store_model import mpm_pkg::*; (
	input  wire logic        core_clk,   // Clock.
	input  wire logic        sys_rst,    // Synchronous reset.
	input  wire logic [15:0] ps_num,     // Parameter looked up.
	output logic             ps_valid,   // Parameter exists.
	output mpm_cls_t         ps_cls,     // Parameter class.
	output logic             ps_wrable,  // Parameter writable.
	output logic      [31:0] ps_rdata,   // Parameter value.
	input  wire logic        ps_wr_en,   // Write strobe.
	input  wire logic [15:0] ps_wr_num,  // Parameter written.
	input  wire logic [31:0] ps_wr_data, // Write value.
	input  wire logic [3:0]  ps_wr_be,   // Byte enables.
	input  wire logic [15:0] scan_num,   // Table entry under check.
	output logic             scan_valid, // Entry names a parameter.
	output mpm_cls_t         scan_cls,   // Entry class.
	output logic      [7:0]  scan_slen,  // Entry string length.
	output logic             scan_pwd,   // Entry is a password.
	output logic             scan_arr    // Entry is a whole array.
);
	typedef struct packed {
		logic        v;
		mpm_cls_t    c;
		logic        w;
		logic [31:0] d;
	} mpm_ans_t;
	logic [15:0] wd_q;
	logic [31:0] dw_q;
	logic [31:0] msk;
	mpm_ans_t    pa;
	mpm_ans_t    sa;
	// Unused bytes carry junk so the bridge must mask them itself.
	function automatic mpm_ans_t ans(input logic [15:0] n);
		case (n)
			16'h0001: ans = '{1'b1, MPM_BYTE, 1'b0, 32'hFFFF_FFA5};
			16'h0002: ans = '{1'b1, MPM_WORD, 1'b1, {16'hC3C3, wd_q}};
			16'h0003: ans = '{1'b1, MPM_DWORD, 1'b1, dw_q};
			16'h0004: ans = '{1'b1, MPM_RAW4, 1'b0, 32'h4433_2211};
			16'h0005: ans = '{1'b1, MPM_BYTE, 1'b0, 32'h5A5A_5A11};
			16'h0007: ans = '{1'b1, MPM_RAW4, 1'b0, 32'h3332_3130};
			16'h0008: ans = '{1'b1, MPM_WORD, 1'b1, 32'h0000_0000};
			16'h000A: ans = '{1'b1, MPM_STR, 1'b1, 32'h3433_3231};
			16'h000B: ans = '{1'b1, MPM_RAW4, 1'b1, 32'h3433_3231};
			16'h000C: ans = '{1'b1, MPM_RAW4, 1'b1, 32'h0000_0035};
			16'h0FFF: ans = '{1'b1, MPM_BYTE, 1'b0, 32'h0000_0042};
			default: ans = '{1'b0, MPM_BYTE, 1'b0, {~n, n}};
		endcase
	endfunction : ans
	always_comb begin
		pa = ans(ps_num);
		sa = ans(scan_num);
		ps_valid = pa.v;
		ps_cls = pa.c;
		ps_wrable = pa.w;
		ps_rdata = pa.d;
		scan_valid = sa.v;
		scan_cls = sa.c;
		scan_slen = (scan_num == 16'h000A) ? 8'h05 : 8'h00;
		scan_pwd = (scan_num == 16'h0008);
		scan_arr = (scan_num == 16'h0004);
		msk = {{8{ps_wr_be[3]}}, {8{ps_wr_be[2]}}, {8{ps_wr_be[1]}}, {8{ps_wr_be[0]}}};
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wd_q <= 16'h1234;
			dw_q <= 32'h89AB_CDEF;
		end else if (ps_wr_en && ps_wr_num == 16'h0002) begin
			wd_q <= (wd_q & ~msk[15:0]) | (ps_wr_data[15:0] & msk[15:0]);
		end else if (ps_wr_en && ps_wr_num == 16'h0003) begin
			dw_q <= (dw_q & ~msk) | (ps_wr_data & msk);
		end
	end
endmodule : mpm_store_model

// [test/tb_modbus_parameter_map.sv]
`timescale 1ns/100ps
`include "mpm_defs.svh"
module tb_modbus_parameter_map import mpm_pkg::*;;
	logic                     core_clk, sys_rst, req_valid, req_ready, req_write, req_first, req_last;
	logic [15:0]              req_addr, req_wdata, rsp_rdata, ps_num, ps_wr_num, scan_num, wr_num_s;
	logic                     rsp_valid, hi_word_first, ps_valid, ps_wrable, ps_wr_en, ps_wr_nul;
	logic [7:0]               rsp_exc, scan_slen;
	logic [31:0]              ps_rdata, ps_wr_data, wr_data_s;
	logic [3:0]               ps_wr_be, wr_be_s;
	logic                     scan_valid, scan_pwd, scan_arr, map_valid, wr_nul_s;
	mpm_cls_t                 ps_cls, scan_cls;
	logic [`MPM_TAB_N*16-1:0] map_tab;
	logic [31:0]              rdq[$];
	logic [31:0]              exq[$];
	int                       mismatches, cmp_count, wr_cnt;
	mpm_bridge u_mpm_bridge (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_first(req_first), .req_last(req_last),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_exc(rsp_exc), .hi_word_first(hi_word_first), .ps_num(ps_num), .ps_valid(ps_valid),
		.ps_cls(ps_cls), .ps_wrable(ps_wrable), .ps_rdata(ps_rdata), .ps_wr_en(ps_wr_en),
		.ps_wr_num(ps_wr_num), .ps_wr_data(ps_wr_data), .ps_wr_be(ps_wr_be), .ps_wr_nul(ps_wr_nul),
		.map_tab(map_tab), .scan_num(scan_num), .scan_valid(scan_valid), .scan_cls(scan_cls),
		.scan_slen(scan_slen), .scan_pwd(scan_pwd), .scan_arr(scan_arr), .map_valid(map_valid));
	mpm_store_model u_mpm_store_model (.core_clk(core_clk), .sys_rst(sys_rst), .ps_num(ps_num),
		.ps_valid(ps_valid), .ps_cls(ps_cls), .ps_wrable(ps_wrable), .ps_rdata(ps_rdata),
		.ps_wr_en(ps_wr_en), .ps_wr_num(ps_wr_num), .ps_wr_data(ps_wr_data), .ps_wr_be(ps_wr_be),
		.scan_num(scan_num), .scan_valid(scan_valid), .scan_cls(scan_cls), .scan_slen(scan_slen),
		.scan_pwd(scan_pwd), .scan_arr(scan_arr));
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (rsp_valid === 1'b1) begin
			rdq.push_back({16'h0000, rsp_rdata});
			exq.push_back({24'h000000, rsp_exc});
		end
		if (ps_wr_en === 1'b1) begin
			wr_cnt++;
			wr_data_s = ps_wr_data;
			wr_be_s = ps_wr_be;
			wr_num_s = ps_wr_num;
			wr_nul_s = ps_wr_nul;
		end
	end
	function automatic logic [15:0] fa(input logic [15:0] n);
		fa = (n - 16'h0001) * 16'h0002 + 16'h0211;
	endfunction : fa
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic beat(input logic w, input logic f, input logic l, input logic [15:0] a, input logic [15:0] d);
		req_valid <= 1'b1;
		req_write <= w;
		req_first <= f;
		req_last <= l;
		req_addr <= a;
		req_wdata <= d;
		@(posedge core_clk);
	endtask : beat
	task automatic idle();
		req_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : idle
	task automatic rdn(input logic [15:0] a, input int n);
		rdq.delete();
		exq.delete();
		for (int i = 0; i < n; i++) beat(1'b0, i == 0, i == n - 1, a + 16'(i), 16'h0000);
		idle();
	endtask : rdn
	task automatic set_tab(input logic [15:0] e0, e1, e2, e3, e4);
		logic [`MPM_TAB_N*16-1:0] t;
		t = '0;
		t[79:0] = {e4, e3, e2, e1, e0};
		map_tab <= t;
		repeat (70) @(posedge core_clk);
	endtask : set_tab
	task automatic t_fixed();
		chk({31'h0, req_ready}, 32'h1, "ready");
		rdn(fa(16'h0001), 2);
		chk(rdq[0], 32'h0000_00A5, "byte register");
		chk(rdq[1], 32'h0000_0000, "byte pad");
		rdn(fa(16'h0002), 2);
		chk(rdq[0], 32'h0000_1234, "word register");
		chk(rdq[1], 32'h0000_0000, "word pad");
		rdn(fa(16'h0004), 3);
		chk(rdq[0], 32'h0000_2211, "array low");
		chk(rdq[1], 32'h0000_4433, "array high");
		chk(rdq[2], 32'h0000_0011, "element zero");
		rdn(fa(16'h0007), 2);
		chk(rdq[0], 32'h0000_3130, "chars 0 1");
		chk(rdq[1], 32'h0000_3332, "chars 2 3");
		hi_word_first <= 1'b0;
		rdn(fa(16'h0003), 2);
		chk(rdq[0], 32'h0000_CDEF, "low word first");
		chk(rdq[1], 32'h0000_89AB, "high word second");
		hi_word_first <= 1'b1;
		rdn(fa(16'h0003), 2);
		chk(rdq[0], 32'h0000_89AB, "high word first");
		chk(rdq[1], 32'h0000_CDEF, "low word second");
		hi_word_first <= 1'b0;
		$display("test fixed mapping done");
	endtask : t_fixed
	task automatic t_exc();
		logic [15:0] a[5];
		logic [31:0] e[5];
		a = '{16'h0000, 16'h220F, fa(16'h0009), fa(16'h0FFF), 16'h0101};
		e = '{32'h02, 32'h02, 32'h02, 32'h00, 32'h00};
		for (int i = 0; i < 5; i++) begin
			rdn(a[i], 1);
			chk(exq[0], e[i], "exception");
		end
		chk(rdq[0], 32'h0000_0000, "reserved read");
		$display("test exceptions done");
	endtask : t_exc
	task automatic t_user();
		int w0;
		set_tab(16'h0002, 16'h0003, 16'h0008, 16'h0004, 16'h0001);
		chk({31'h0, map_valid}, 32'h0, "map valid");
		rdn(16'h0001, 5);
		chk(rdq[0], 32'h0000_1234, "user word");
		chk(rdq[1], 32'h0000_CDEF, "user dword low");
		chk(rdq[2], 32'h0000_89AB, "user dword high");
		chk(rdq[3], 32'h0000_00A5, "user byte");
		chk(rdq[4], 32'h0000_0000, "user unmapped");
		chk(exq[4], 32'h0000_0000, "user exception");
		rdn(16'h0100, 1);
		chk(exq[0], 32'h0000_0000, "last user register");
		set_tab(16'h0002, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
		rdn(16'h0001, 2);
		chk(rdq[1], 32'h0000_0000, "after zero entry");
		set_tab(16'h0002, 16'h0003, 16'h0001, 16'h000A, 16'h0000);
		chk({31'h0, map_valid}, 32'h1, "map valid");
		rdn(16'h0005, 3);
		chk(rdq[0], 32'h0000_3231, "string chars 0 1");
		chk(rdq[1], 32'h0000_3433, "string chars 2 3");
		chk(rdq[2], 32'h0000_0035, "string tail");
		w0 = wr_cnt;
		beat(1'b1, 1'b1, 1'b1, 16'h0006, 16'h4141);
		idle();
		chk(32'(wr_cnt - w0), 32'h0, "string mid write");
		beat(1'b1, 1'b1, 1'b0, 16'h0005, 16'h4241);
		beat(1'b1, 1'b0, 1'b0, 16'h0006, 16'h4443);
		beat(1'b1, 1'b0, 1'b1, 16'h0007, 16'h4645);
		idle();
		chk(32'(wr_cnt - w0), 32'h3, "string writes");
		chk({31'h0, wr_nul_s}, 32'h1, "string null added");
		chk({16'h0, wr_num_s}, 32'h0000_000C, "string fragment");
		$display("test user mapping done");
	endtask : t_user
	task automatic t_write();
		int w0;
		w0 = wr_cnt;
		beat(1'b1, 1'b1, 1'b0, fa(16'h0003), 16'h5678);
		beat(1'b1, 1'b0, 1'b1, fa(16'h0003) + 16'h0001, 16'h1234);
		idle();
		chk(32'(wr_cnt - w0), 32'h1, "dword commits");
		chk(wr_data_s, 32'h1234_5678, "dword value");
		chk({16'h0, wr_num_s}, 32'h0000_0003, "dword number");
		chk({28'h0, wr_be_s}, 32'hF, "dword enables");
		beat(1'b1, 1'b1, 1'b1, fa(16'h0003), 16'hAAAA);
		idle();
		beat(1'b1, 1'b1, 1'b1, fa(16'h0003) + 16'h0001, 16'hBBBB);
		idle();
		beat(1'b1, 1'b1, 1'b1, fa(16'h0002) + 16'h0001, 16'hCCCC);
		idle();
		chk(32'(wr_cnt - w0), 32'h1, "lone writes");
		rdn(fa(16'h0003), 2);
		chk(rdq[0], 32'h0000_5678, "dword low kept");
		chk(rdq[1], 32'h0000_1234, "dword high kept");
		beat(1'b1, 1'b1, 1'b1, fa(16'h0002), 16'hBEEF);
		idle();
		chk({28'h0, wr_be_s}, 32'h3, "word enables");
		rdn(fa(16'h0002), 1);
		chk(rdq[0], 32'h0000_BEEF, "word readback");
		$display("test writes done");
	endtask : t_write
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		mismatches++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		{req_valid, req_write, req_first, req_last, hi_word_first} = 5'h00;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		map_tab = '0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_fixed();
		t_exc();
		t_user();
		t_write();
		end_sim();
	end
endmodule : tb_modbus_parameter_map
